// ---- core/kbli_pkg.sv ----
package kbli_pkg;
  // ----------------------------------------
  // widths and register map
  // ----------------------------------------
  localparam int KBLI_LINES = 8;
  localparam int KBLI_AW = 8;
  localparam logic [7:0] KBLI_ADDR_LEVEL_SELECT = 8'h9c;
  localparam logic [7:0] KBLI_ADDR_LINE_ENABLE = 8'h9d;
  localparam logic [7:0] KBLI_ADDR_LINE_FLAGS = 8'h9e;
  localparam logic [7:0] KBLI_RESET_VALUE = 8'h00;
  localparam logic [7:0] KBLI_READ_UNMAPPED = 8'h00;

  // ----------------------------------------
  // register bus carrier
  // ----------------------------------------
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } kbli_sfr_req_type;

  typedef enum logic [2:0] {
    KBLI_RUN = 3'b001,
    KBLI_WAKE = 3'b010,
    KBLI_SLEEP = 3'b100
  } kbli_pwr_type;
endpackage

// ---- core/kbli_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module kbli_sync (
  input wire logic clk, // clock
  input wire logic reset_n, // sync reset
  input wire logic [7:0] asyncIn, // raw port lines
  output logic [7:0] syncOut // synchronized lines
);
  import kbli_pkg::*;
  logic [7:0] stage1_r;
  logic [7:0] stage1_nxt;
  logic [7:0] stage2_nxt;

  always_comb begin
    stage1_nxt = asyncIn;
    stage2_nxt = stage1_r;
    if (!reset_n) begin
      // released lines idle at their pull-up level, no false low
      stage1_nxt = ~KBLI_RESET_VALUE;
      stage2_nxt = ~KBLI_RESET_VALUE;
    end
  end

  always_ff @(posedge clk) begin
    stage1_r <= stage1_nxt;
    syncOut <= stage2_nxt;
  end
endmodule
`default_nettype wire

// ---- core/kbli_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module kbli_top
  import kbli_pkg::*;
(
  input wire logic clk, // 40 MHz clock
  input wire logic reset_n, // sync reset, active low
  input wire kbli_pkg::kbli_sfr_req_type sfrReq, // register access
  output logic [7:0] sfrRdData, // read data, one cycle after rdEn
  input wire logic [7:0] portOne, // port lines from key matrix
  input wire logic keyIrqGlobalEnable, // global keyboard enable
  input wire logic sleepMode, // core in idle or power-down
  output logic keyIrqRequest, // combined keyboard request
  output logic wakeRequest // wake from reduced power
);
  import kbli_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] keyLevelSelect_r, keyLevelSelect_nxt;
  logic [7:0] keyLineEnable_r, keyLineEnable_nxt;
  logic [7:0] keyLineFlags_r, keyLineFlags_nxt;
  logic [7:0] rdData_nxt;
  logic irq_nxt;
  logic wake_nxt;
  logic [7:0] portSync;
  logic [7:0] detect;
  kbli_pwr_type pwr_r, pwr_nxt;

  function automatic logic hit(input kbli_sfr_req_type r,
                               input logic [7:0] a);
    hit = (r.addr == a);
  endfunction

  kbli_sync i_kbli_sync (
    .clk(clk),
    .reset_n(reset_n),
    .asyncIn(portOne),
    .syncOut(portSync)
  );

  // ----------------------------------------
  // detection and registers
  // ----------------------------------------
  always_comb begin
    detect = ~(portSync ^ keyLevelSelect_r);
    keyLevelSelect_nxt = keyLevelSelect_r;
    keyLineEnable_nxt = keyLineEnable_r;
    keyLineFlags_nxt = keyLineFlags_r;
    if (sfrReq.wrEn && hit(sfrReq, KBLI_ADDR_LEVEL_SELECT))
      keyLevelSelect_nxt = sfrReq.wrData;
    if (sfrReq.wrEn && hit(sfrReq, KBLI_ADDR_LINE_ENABLE))
      keyLineEnable_nxt = sfrReq.wrData;
    if (sfrReq.wrEn && hit(sfrReq, KBLI_ADDR_LINE_FLAGS))
      keyLineFlags_nxt = sfrReq.wrData;
    keyLineFlags_nxt = keyLineFlags_nxt | detect;
    rdData_nxt = KBLI_READ_UNMAPPED;
    if (sfrReq.rdEn) begin
      if (hit(sfrReq, KBLI_ADDR_LEVEL_SELECT))
        rdData_nxt = keyLevelSelect_r;
      else if (hit(sfrReq, KBLI_ADDR_LINE_ENABLE))
        rdData_nxt = keyLineEnable_r;
      else if (hit(sfrReq, KBLI_ADDR_LINE_FLAGS))
        rdData_nxt = keyLineFlags_r;
    end
    irq_nxt = keyIrqGlobalEnable
              && |(keyLineFlags_r & keyLineEnable_r);
    if (!reset_n) begin
      keyLevelSelect_nxt = KBLI_RESET_VALUE;
      keyLineEnable_nxt = KBLI_RESET_VALUE;
      keyLineFlags_nxt = KBLI_RESET_VALUE;
      rdData_nxt = KBLI_RESET_VALUE;
      irq_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    keyLevelSelect_r <= keyLevelSelect_nxt;
    keyLineEnable_r <= keyLineEnable_nxt;
    keyLineFlags_r <= keyLineFlags_nxt;
    sfrRdData <= rdData_nxt;
    keyIrqRequest <= irq_nxt;
  end

  // ----------------------------------------
  // wake from reduced power
  // ----------------------------------------
  always_comb begin
    pwr_nxt = pwr_r;
    wake_nxt = 1'b0;
    case (pwr_r)
      KBLI_RUN: begin
        if (sleepMode)
          pwr_nxt = KBLI_SLEEP;
      end
      KBLI_SLEEP: begin
        if (!sleepMode)
          pwr_nxt = KBLI_RUN;
        else if (|(keyLineFlags_r & keyLineEnable_r)) begin
          pwr_nxt = KBLI_WAKE;
          wake_nxt = 1'b1;
        end
      end
      KBLI_WAKE: begin
        wake_nxt = sleepMode;
        if (!sleepMode)
          pwr_nxt = KBLI_RUN;
      end
      default: pwr_nxt = KBLI_RUN;
    endcase
    if (!reset_n) begin
      pwr_nxt = KBLI_RUN;
      wake_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    pwr_r <= pwr_nxt;
    wakeRequest <= wake_nxt;
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_flag_set_level: assert property (
    ((portSync ^ keyLevelSelect_r) != 8'hff)
    |=> ((keyLineFlags_r | $past(portSync ^ keyLevelSelect_r)) == 8'hff))
    else $error("matching level did not set a flag");
  a_flag_no_hwclear: assert property (
    !(sfrReq.wrEn && hit(sfrReq, KBLI_ADDR_LINE_FLAGS))
    |=> ((keyLineFlags_r & $past(keyLineFlags_r)) == $past(keyLineFlags_r)))
    else $error("flag cleared without software write");
  a_irq_masked: assert property (
    ((keyLineFlags_r & keyLineEnable_r) == 8'h00) |=> !keyIrqRequest)
    else $error("request without enabled flag");
  a_irq_global: assert property (
    !keyIrqGlobalEnable |=> !keyIrqRequest)
    else $error("request with global enable clear");
  a_irq_raise: assert property (
    (keyIrqGlobalEnable && |(keyLineFlags_r & keyLineEnable_r))
    |=> keyIrqRequest)
    else $error("enabled flag gave no request");
  a_enable_write: assert property (
    (sfrReq.wrEn && sfrReq.addr == KBLI_ADDR_LINE_ENABLE)
    |=> keyLineEnable_r == $past(sfrReq.wrData))
    else $error("enable register write lost");
  a_level_read: assert property (
    (sfrReq.rdEn && sfrReq.addr == KBLI_ADDR_LEVEL_SELECT)
    |=> sfrRdData == $past(keyLevelSelect_r))
    else $error("level select read wrong");
  a_reset_zero: assert property (
    @(posedge clk) disable iff (1'b0)
    !reset_n |=> (keyLineFlags_r == 8'h00 && keyLineEnable_r == 8'h00))
    else $error("registers not zero after reset");
  a_wake_sleep: assert property (
    (pwr_r == KBLI_SLEEP && sleepMode
     && |(keyLineFlags_r & keyLineEnable_r)) |=> wakeRequest)
    else $error("no wake on detection");
  a_flag_write: assert property (
    (sfrReq.wrEn && hit(sfrReq, KBLI_ADDR_LINE_FLAGS))
    |=> ((keyLineFlags_r & $past(portSync ^ keyLevelSelect_r))
    == ($past(sfrReq.wrData) & $past(portSync ^ keyLevelSelect_r))))
    else $error("flag write lost");
  a_level_write: assert property (
    (sfrReq.wrEn && sfrReq.addr == KBLI_ADDR_LEVEL_SELECT)
    |=> keyLevelSelect_r == $past(sfrReq.wrData))
    else $error("level select write lost");
  a_other_write: assert property (
    (sfrReq.wrEn && sfrReq.addr != KBLI_ADDR_LEVEL_SELECT
     && sfrReq.addr != KBLI_ADDR_LINE_ENABLE)
    |=> ($stable(keyLevelSelect_r) && $stable(keyLineEnable_r)))
    else $error("write changed another register");
  a_flags_read: assert property (
    (sfrReq.rdEn && sfrReq.addr == KBLI_ADDR_LINE_FLAGS)
    |=> sfrRdData == $past(keyLineFlags_r))
    else $error("flag read wrong");
  a_enable_read: assert property (
    (sfrReq.rdEn && sfrReq.addr == KBLI_ADDR_LINE_ENABLE)
    |=> sfrRdData == $past(keyLineEnable_r))
    else $error("enable read wrong");
  a_idle_read: assert property (
    !sfrReq.rdEn |=> sfrRdData == KBLI_READ_UNMAPPED)
    else $error("read data without read");
  a_reset_outputs: assert property (
    @(posedge clk) disable iff (1'b0)
    !reset_n |=> (!keyIrqRequest && !wakeRequest
      && sfrRdData == KBLI_RESET_VALUE
      && keyLevelSelect_r == KBLI_RESET_VALUE))
    else $error("outputs not cleared by reset");
  a_wake_clear: assert property (
    !sleepMode |=> !wakeRequest)
    else $error("wake while running");
  a_pwr_onehot: assert property (
    $onehot(pwr_r))
    else $error("power state not one-hot");
  a_sync_delay: assert property (
    ($past(reset_n) && $past(reset_n, 2))
    |-> portSync == $past(portOne, 2))
    else $error("port lines not delayed two clocks");

  // ----------------------------------------
  // cover points
  // ----------------------------------------
  c_irq: cover property (keyIrqRequest);
  c_wake: cover property (wakeRequest);
  c_clear: cover property (sfrReq.wrEn
    && sfrReq.addr == KBLI_ADDR_LINE_FLAGS && sfrReq.wrData == 8'h00);
  c_set_wins: cover property (sfrReq.wrEn
    && sfrReq.addr == KBLI_ADDR_LINE_FLAGS
    && (portSync ^ keyLevelSelect_r) != 8'hff);
  c_global_off: cover property (!keyIrqGlobalEnable
    && |(keyLineFlags_r & keyLineEnable_r));
endmodule
`default_nettype wire

// ---- bench/kbli_key_matrix.sv ----
`timescale 1ns/10ps
`default_nettype none
module kbli_key_matrix (
  input wire logic [7:0] keyDown, // keys held, one bit a line
  output logic [7:0] portOne // port lines with pull-ups
);
  // held key pulls its line low, a free line sits at the pull-up
  assign portOne = ~keyDown;
endmodule
`default_nettype wire

// ---- bench/keypad_level_interrupt_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module keypad_level_interrupt_bench;
  import kbli_pkg::*;
  logic clk, reset_n, glbEn, sleepMode, irq, wake;
  logic [7:0] rdData, portOne, keyDown;
  kbli_sfr_req_type sfrReq;
  int badCount, numChecks;
  kbli_top i_kbli_top(.clk(clk), .reset_n(reset_n), .sfrReq(sfrReq),
    .sfrRdData(rdData), .portOne(portOne), .keyIrqGlobalEnable(glbEn),
    .sleepMode(sleepMode), .keyIrqRequest(irq), .wakeRequest(wake));
  kbli_key_matrix i_kbli_key_matrix(.keyDown(keyDown), .portOne(portOne));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    numChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    sfrReq <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    sfrReq <= '0;
  endtask
  task automatic rdChk(logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    sfrReq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    sfrReq <= '0;
    @(negedge clk);
    check("read data", rdData, exp);
  endtask
  task automatic outChk(int n, logic expIrq, logic expWake);
    repeat (n) @(posedge clk);
    @(negedge clk);
    check("request", {7'h00, irq}, {7'h00, expIrq});
    check("wake", {7'h00, wake}, {7'h00, expWake});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic tRegs;
    rdChk(KBLI_ADDR_LEVEL_SELECT, 8'h00);
    rdChk(KBLI_ADDR_LINE_ENABLE, 8'h00);
    rdChk(KBLI_ADDR_LINE_FLAGS, 8'h00);
    wr(KBLI_ADDR_LINE_ENABLE, 8'ha5);
    wr(KBLI_ADDR_LEVEL_SELECT, 8'h3c);
    wr(8'h9f, 8'hff);
    rdChk(KBLI_ADDR_LINE_ENABLE, 8'ha5);
    rdChk(KBLI_ADDR_LEVEL_SELECT, 8'h3c);
    rdChk(8'h9f, 8'h00);
    rdChk(KBLI_ADDR_LINE_FLAGS, 8'h3c);
    wr(KBLI_ADDR_LEVEL_SELECT, 8'h00);
    wr(KBLI_ADDR_LINE_ENABLE, 8'h00);
    wr(KBLI_ADDR_LINE_FLAGS, 8'h00);
    rdChk(KBLI_ADDR_LINE_FLAGS, 8'h00);
  endtask
  task automatic tLow;
    @(posedge clk);
    keyDown <= 8'h08;
    outChk(6, 1'b0, 1'b0);
    rdChk(KBLI_ADDR_LINE_FLAGS, 8'h08);
    @(posedge clk);
    glbEn <= 1'b1;
    outChk(3, 1'b0, 1'b0);
    wr(KBLI_ADDR_LINE_ENABLE, 8'h08);
    outChk(3, 1'b1, 1'b0);
    @(posedge clk);
    glbEn <= 1'b0;
    outChk(2, 1'b0, 1'b0);
    @(posedge clk);
    glbEn <= 1'b1;
    outChk(2, 1'b1, 1'b0);
    @(posedge clk);
    keyDown <= 8'h00;
    outChk(4, 1'b1, 1'b0);
    wr(KBLI_ADDR_LINE_FLAGS, 8'h00);
    rdChk(KBLI_ADDR_LINE_FLAGS, 8'h00);
    outChk(2, 1'b0, 1'b0);
  endtask
  task automatic tHigh;
    wr(KBLI_ADDR_LEVEL_SELECT, 8'h20);
    wr(KBLI_ADDR_LINE_ENABLE, 8'h20);
    sleepMode <= 1'b1;
    outChk(6, 1'b1, 1'b1);
    rdChk(KBLI_ADDR_LINE_FLAGS, 8'h20);
    wr(KBLI_ADDR_LINE_FLAGS, 8'h00);
    rdChk(KBLI_ADDR_LINE_FLAGS, 8'h20);
    @(posedge clk);
    keyDown <= 8'h20;
    sleepMode <= 1'b0;
    repeat (4) @(posedge clk);
    wr(KBLI_ADDR_LINE_FLAGS, 8'h00);
    rdChk(KBLI_ADDR_LINE_FLAGS, 8'h00);
    outChk(2, 1'b0, 1'b0);
  endtask
  task automatic tReset;
    wr(KBLI_ADDR_LINE_ENABLE, 8'hff);
    wr(KBLI_ADDR_LINE_FLAGS, 8'hff);
    outChk(2, 1'b1, 1'b0);
    @(posedge clk);
    keyDown <= 8'h00;
    reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    outChk(1, 1'b0, 1'b0);
    rdChk(KBLI_ADDR_LEVEL_SELECT, 8'h00);
    rdChk(KBLI_ADDR_LINE_ENABLE, 8'h00);
    rdChk(KBLI_ADDR_LINE_FLAGS, 8'h00);
  endtask
  task automatic stopTest;
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    badCount++;
    stopTest();
  end
  initial begin
    sfrReq = '0;
    keyDown = 8'h00;
    glbEn = 1'b0;
    sleepMode = 1'b0;
    reset_n = 1'b0;
    badCount = 0;
    numChecks = 0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    tRegs();
    tLow();
    tHigh();
    tReset();
    stopTest();
  end
endmodule
`default_nettype wire
